// ---- dv/acs_capture_sva.sv ----
/*
 * Port checker for the converter capture sequencer.
 * Assumes it is bound to the top module and sees one clock domain.
 */
`timescale 1ns/10ps
module acs_capture_sva
    import acs_pkg::*;
(
    // Clock and reset.
    input wire logic                    sys_clk,
    input wire logic                    reset,
    // Processor side.
    input wire logic                    armCapture,
    input wire logic                    blockDoneIrq,
    input wire logic                    captureActive,
    input wire logic                    captureComplete,
    // Serial side.
    input wire logic                    serialClockOut,
    input wire logic                    frameSyncOutN,
    input wire logic                    receiveReady,
    // Capture buffer side.
    input wire logic [STORE_ADDR_W-1:0] memWrAddr,
    input wire logic [FIFO_WIDTH-1:0]   memWrData,
    input wire logic                    memWrEn,
    input wire logic                    memWrReady
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);

    logic [5:0]              lowCnt_r;
    logic [4:0]              riseCnt_r;
    logic [STORE_ADDR_W-1:0] lastAddr_r;
    logic                    seenWr_r;
    logic                    wrTaken;

    assign wrTaken = memWrEn && memWrReady && memWrAddr != DISCARD_ADDR;

    always_ff @(posedge sys_clk) begin
        if (reset || frameSyncOutN) begin
            lowCnt_r  <= 6'h00;
            riseCnt_r <= 5'h00;
        end else begin
            lowCnt_r  <= lowCnt_r + 6'h01;
            riseCnt_r <= riseCnt_r + 5'($rose(serialClockOut));
        end
    end

    // An arm restarts the address run, so the last address is forgotten there.
    always_ff @(posedge sys_clk) begin
        if (reset || armCapture) begin
            seenWr_r <= 1'h0;
        end else if (wrTaken) begin
            seenWr_r   <= 1'h1;
            lastAddr_r <= memWrAddr;
        end
    end

    frame_shape_a: assert property ($rose(frameSyncOutN) && !$past(reset) |-> riseCnt_r == 5'h10
        && lowCnt_r inside {6'h21, 6'h22}) else $error("frame length or clock count wrong");
    clock_stop_a: assert property (frameSyncOutN |-> !serialClockOut)
        else $error("serial clock runs outside a frame");
    rx_ready_a: assert property ($rose(frameSyncOutN) && !$past(reset) |-> ##[0:1] receiveReady
        ##1 !receiveReady) else $error("receive ready pulse missing");
    wr_hold_a: assert property (memWrEn && !memWrReady && !armCapture |=> memWrEn && $stable(memWrAddr)
        && $stable(memWrData)) else $error("write changed before accepted");
    addr_step_a: assert property (wrTaken |-> memWrAddr == (seenWr_r ? lastAddr_r + 17'h00001 : 17'h00000))
        else $error("write address not consecutive");
    discard_a: assert property (captureComplete && wrTaken && !armCapture ##1 memWrEn |-> memWrAddr == DISCARD_ADDR)
        else $error("write after block end not discarded");
    irq_once_a: assert property (blockDoneIrq |-> captureComplete && memWrAddr == 17'h0FFFF ##1 !blockDoneIrq)
        else $error("completion pulse wrong");
    complete_irq_a: assert property ($rose(captureComplete) |-> blockDoneIrq)
        else $error("block end without interrupt");
    arm_start_a: assert property (armCapture |=> captureActive && !captureComplete)
        else $error("arm did not start capture");
endmodule

bind acs_capture_sequencer acs_capture_sva i_sva (.sys_clk, .reset, .armCapture, .blockDoneIrq, .captureActive,
    .captureComplete, .serialClockOut, .frameSyncOutN, .receiveReady, .memWrAddr, .memWrData, .memWrEn, .memWrReady);

// ---- dv/acs_converter_model.sv ----
/*
 * Behavioural model of the serial converter beside the sequencer.
 * Assumes the bench sets conversion spacing and supplies sample noise.
 */
`timescale 1ns/10ps
module acs_converter_model
    import acs_pkg::*;
(
    // Clock and bench control.
    input wire logic        sys_clk,
    input wire logic        runConv,
    input wire logic [7:0]  convGap,
    input wire logic [14:0] noise,
    // Converter pins.
    output logic            conversionDone,
    output logic            converterSerialOut,
    input wire logic        serialClockOut,
    input wire logic        frameSyncOutN,
    input wire logic        converterSerialIn
);
    logic [15:0] result = 16'h0000;
    logic [15:0] shiftOut, shiftIn, lastSent, lastCmd;
    logic        chanSel = 1'h0;
    int          tick = 0;
    int          frameCnt = 0;
    int          convCnt = 0;
    logic [15:0] sentWords[$];

    initial begin
        conversionDone = CONV_DONE_IDLE;
        converterSerialOut = 1'h0;
    end

    always @(posedge sys_clk) begin
        // A begun conversion finishes its low pulse even when the bench stops.
        tick <= ((runConv || tick != 0) && tick < convGap) ? tick + 1 : 0;
        conversionDone <= !((runConv || tick != 0) && tick < 4);
        convCnt <= convCnt + int'(runConv && tick == 0);
    end

    // Results change on the falling clock so a frame start never races them.
    always @(negedge sys_clk) begin
        if (frameSyncOutN)
            converterSerialOut <= !converterSerialOut;
        if (runConv && tick == convGap) begin
            result  <= {chanSel, noise};
            chanSel <= !chanSel;
        end
    end

    always @(negedge frameSyncOutN) begin
        shiftOut = result;
        converterSerialOut = result[15];
        lastSent = result;
        sentWords.push_back(result);
        frameCnt++;
    end
    always @(negedge serialClockOut) begin
        if (!frameSyncOutN) begin
            shiftOut = shiftOut << 1;
            converterSerialOut = shiftOut[15];
        end
    end
    always @(posedge serialClockOut) shiftIn = {shiftIn[14:0], converterSerialIn};
    always @(posedge frameSyncOutN) lastCmd = shiftIn;
endmodule

// ---- dv/adc_sample_capture_sequencer_tb_top.sv ----
/*
 * Self-checking bench for the converter capture sequencer.
 * Assumes the converter model and the port checker are compiled with it.
 */
`timescale 1ns/10ps
module adc_sample_capture_sequencer_tb_top
    import acs_pkg::*;
;
    logic                    sys_clk, reset, armCapture, memWrReady, runConv, stallAll, rrPrev;
    logic                    conversionDone, serialClockOut, frameSyncOutN, converterSerialIn, converterSerialOut;
    logic                    blockDoneIrq, captureActive, captureComplete, sampleOverrun, receiveReady, memWrEn;
    logic [FRAME_BITS-1:0]   receiveWordReg;
    logic [STORE_ADDR_W-1:0] memWrAddr, expAddr;
    logic [FIFO_WIDTH-1:0]   memWrData;
    logic [14:0]             noise;
    logic [7:0]              convGap;
    int                      errorCnt, testsRun, irqCnt, frames0, conv0, seedVal;

    acs_capture_sequencer i_dut (.sys_clk, .reset, .armCapture, .blockDoneIrq, .captureActive, .captureComplete,
        .sampleOverrun, .conversionDone, .serialClockOut, .frameSyncOutN, .converterSerialIn, .converterSerialOut,
        .receiveReady, .receiveWordReg, .memWrAddr, .memWrData, .memWrEn, .memWrReady);
    acs_converter_model i_conv (.sys_clk, .runConv, .convGap, .noise, .conversionDone, .converterSerialOut,
        .serialClockOut, .frameSyncOutN, .converterSerialIn);

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            errorCnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic completeRun();
        $display("comparisons %0d, mismatches %0d", testsRun, errorCnt);
        if (errorCnt == 0 && testsRun > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    task automatic drain();
        runConv <= 1'h0;
        tick(100);
        for (int i = 0; i < 4000 && i_conv.sentWords.size() != 0; i++)
            @(posedge sys_clk);
        tick(4);
        check(i_conv.sentWords.size(), 0);
    endtask

    // Arms from a quiet state, runs n spells of random spacing, then drains.
    task automatic capture(input int n);
        runConv <= 1'h0;
        tick(10);
        frames0 = i_conv.frameCnt;
        conv0 = i_conv.convCnt;
        armCapture <= 1'h1;
        expAddr = 17'h00000;
        tick(1);
        armCapture <= 1'h0;
        tick(1);
        check({captureActive, sampleOverrun}, 2'h2);
        runConv <= 1'h1;
        repeat (n) begin
            convGap <= 8'(44 + $urandom % 40);
            tick(70);
        end
        drain();
        check(i_conv.frameCnt - frames0, i_conv.convCnt - conv0);
        check(sampleOverrun, 1'h0);
    endtask

    always @(posedge sys_clk) begin
        rrPrev <= receiveReady === 1'h1;
        if (rrPrev && !reset) begin
            check(receiveWordReg, i_conv.lastSent);
            check(i_conv.lastCmd, CMD_READ_DATA);
        end
        if (memWrEn === 1'h1 && memWrReady && !reset) begin
            check(memWrAddr, expAddr);
            check(memWrData, i_conv.sentWords.pop_front());
            expAddr = expAddr + 17'h00001;
        end
        irqCnt += int'(blockDoneIrq === 1'h1);
    end

    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end

    // The plan takes about 28k cycles; this limit allows well over twice that.
    initial begin
        #2_000_000;
        errorCnt++;
        completeRun();
    end

    initial begin
        reset = 1'h1;
        armCapture = 1'h0;
        memWrReady = 1'h0;
        runConv = 1'h0;
        stallAll = 1'h0;
        convGap = 8'h2C;
        noise = 15'h0000;
        expAddr = 17'h00000;
        errorCnt = 0;
        testsRun = 0;
        irqCnt = 0;
        seedVal = $urandom(1);
        fork
            forever begin
                @(posedge sys_clk);
                noise <= 15'($urandom);
                memWrReady <= !stallAll && ($urandom % 4 != 0);
            end
        join_none
        tick(16);
        reset <= 1'h0;
        tick(2);
        check({frameSyncOutN, serialClockOut, memWrEn, captureActive, captureComplete}, 5'h10);
        runConv <= 1'h1;
        tick(400);
        check(i_conv.frameCnt, 0);
        $display("test idle_disarmed done");
        capture(300);
        $display("test random_capture done");
        stallAll <= 1'h1;
        frames0 = i_conv.frameCnt;
        convGap <= 8'h2C;
        runConv <= 1'h1;
        tick(3000);
        check((i_conv.frameCnt - frames0) inside {[33:36]}, 1'h1);
        check({sampleOverrun, frameSyncOutN}, 2'h3);
        stallAll <= 1'h0;
        drain();
        $display("test buffer_full done");
        capture(20);
        $display("test rearm done");
        runConv <= 1'h1;
        tick(500);
        reset <= 1'h1;
        tick(2);
        reset <= 1'h0;
        i_conv.sentWords.delete();
        tick(2);
        check({frameSyncOutN, serialClockOut, memWrEn, captureActive}, 4'h8);
        frames0 = i_conv.frameCnt;
        tick(300);
        check(i_conv.frameCnt - frames0, 0);
        capture(20);
        check({irqCnt[0], captureComplete}, 2'h0);
        $display("test midrun_reset done");
        completeRun();
    end
endmodule

// ---- verilog/acs_capture_sequencer.sv ----
/*
 * Converter capture sequencer: reacts to conversion-done edges, reads each
 * result over a clock-stop serial frame and writes a block of words into an
 * external capture buffer, then raises one completion pulse.
 * Assumes the converter runs its own triggering and channel alternation, a
 * capture buffer that takes writes on a valid/ready port, and a processor that
 * re-arms the block with a one-cycle pulse on the system clock.
 */
`timescale 1ns/10ps
// How it works
// - The converter triggers itself and alternates channels, so this block never sends a start command.
// - A block holds 32,768 words from each of the two channels.
// - The command transfer is requested only by the converter's conversion-done pin.
// - While armed, each falling edge of conversion-done loads the read command into the transmit word register.
// - Loading the transmit word register starts one frame that shifts the command out on the data line.
// - At the end of a 16-bit frame a receive-ready pulse shows the word held in the receive word register.
// - Storing is requested only by the receive-ready pulse.
// - Each received word goes to the next consecutive capture buffer location.
// - After 65,536 stored words, later words go to one discard location.
// - One completion pulse is raised per block, never per sample.
// - Serial clock, frame select, data out and data in connect to the matching converter pins.
// - Conversion-done arrives on the external event input that requests the command transfer.
// - A high-to-low change of conversion-done ends a conversion; the line idles high.
// - Frames are 16-bit clock-stop frames with data delayed one serial clock after frame start.
// - The serial clock is divided down from the system clock toward a 37.5 MHz reference rate.
module acs_capture_sequencer
    import acs_pkg::*;
(
    // Clock and reset.
    input  wire  logic                    sys_clk,
    input  wire  logic                    reset,
    // Processor control and status.
    input  wire  logic                    armCapture,
    output logic                          blockDoneIrq,
    output logic                          captureActive,
    output logic                          captureComplete,
    output logic                          sampleOverrun,
    // Converter pins.
    input  wire  logic                    conversionDone,
    output logic                          serialClockOut,
    output logic                          frameSyncOutN,
    output logic                          converterSerialIn,
    input  wire  logic                    converterSerialOut,
    // Serial port receive side.
    output logic                          receiveReady,
    output logic [FRAME_BITS-1:0]         receiveWordReg,
    // Capture buffer write port.
    output logic [STORE_ADDR_W-1:0]       memWrAddr,
    output logic [FIFO_WIDTH-1:0]         memWrData,
    output logic                          memWrEn,
    input  wire  logic                    memWrReady
);

    // Event input synchroniser and filtered level.
    logic                    cdSync1_r;
    logic                    cdSync2_r;
    logic                    cdSync3_r;
    logic                    cdLevel_r;

    // Sequencer and serial port state.
    acs_seq_state_t          seq_r;
    acs_seq_state_t          seq_nxt;
    acs_ser_state_t          ser_r;
    acs_ser_state_t          ser_nxt;
    logic [3:0]              halfCnt_r;
    logic [4:0]              bitCnt_r;
    logic                    sclk_r;
    logic                    frameSel_r;
    logic                    serialOut_r;
    logic [FRAME_BITS-1:0]   transmitWord_r;
    logic                    txPending_r;
    logic                    txPending_nxt;
    logic [FRAME_BITS-1:0]   txShift_r;
    logic [FRAME_BITS-1:0]   rxShift_r;
    logic [FRAME_BITS-1:0]   receiveWord_r;
    logic                    receiveReady_r;
    logic                    overrun_r;

    // Store side.
    logic [STORE_ADDR_W-1:0] storeCount_r;
    logic [STORE_ADDR_W-1:0] memWrAddr_r;
    logic [FIFO_WIDTH-1:0]   memWrData_r;
    logic                    memWrEn_r;
    logic                    blockDone_r;
    logic                    captureActive_r;
    logic                    captureComplete_r;

    acs_stream_if #(.WIDTH(FIFO_WIDTH)) fifoIn ();
    acs_stream_if #(.WIDTH(FIFO_WIDTH)) fifoOut ();

    function automatic logic isCapturing(input logic [STORE_ADDR_W-1:0] count);
        isCapturing = (count < BLOCK_WORDS_W);
    endfunction

    function automatic logic [STORE_ADDR_W-1:0] storeAddr(input logic [STORE_ADDR_W-1:0] count);
        storeAddr = isCapturing(count) ? count : DISCARD_ADDR;
    endfunction

    // Decoding of events and serial clock phases.
    wire armed      = (seq_r != SEQ_DISARMED);
    wire cdAgree    = (cdSync2_r == cdSync3_r);
    wire cdFall     = cdLevel_r && cdAgree && !cdSync3_r;
    wire cmdLoad    = armed && cdFall;
    wire halfTick   = (halfCnt_r == 4'(SCLK_HALF_CYC - 1));
    wire frameStart = (ser_r == SER_IDLE) && txPending_r && fifoIn.ready;
    wire leadDone   = (ser_r == SER_LEAD) && halfTick && (bitCnt_r == 5'(LEAD_HALVES - 1));
    wire riseTick   = (ser_r == SER_SHIFT) && halfTick && !sclk_r;
    wire fallTick   = (ser_r == SER_SHIFT) && halfTick && sclk_r;
    wire lastBit    = (bitCnt_r == 5'(FRAME_BITS - 1));
    wire frameEnd   = fallTick && lastBit;
    wire storeTake  = fifoOut.valid && fifoOut.ready;
    wire blockLast  = storeTake && (seq_r == SEQ_CAPTURE) && (storeCount_r == BLOCK_WORDS_W - 1'h1);

    assign fifoIn.data   = receiveWord_r;
    assign fifoIn.valid  = receiveReady_r;
    // The writer drains while no write is waiting or the buffer port accepts, so a slow port backs up into frame starts.
    assign fifoOut.ready = !memWrEn_r || memWrReady;

    assign serialClockOut    = sclk_r;
    assign frameSyncOutN     = frameSel_r;
    assign converterSerialIn = serialOut_r;
    assign receiveReady      = receiveReady_r;
    assign receiveWordReg    = receiveWord_r;
    assign memWrAddr         = memWrAddr_r;
    assign memWrData         = memWrData_r;
    assign memWrEn           = memWrEn_r;
    assign blockDoneIrq      = blockDone_r;
    assign captureActive     = captureActive_r;
    assign captureComplete   = captureComplete_r;
    assign sampleOverrun     = overrun_r;

    acs_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk     (sys_clk),
        .reset   (reset),
        .flush   (armCapture),
        .inPort  (fifoIn),
        .outPort (fifoOut)
    );

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cdSync1_r <= CONV_DONE_IDLE;
            cdSync2_r <= CONV_DONE_IDLE;
            cdSync3_r <= CONV_DONE_IDLE;
        end else begin
            cdSync1_r <= conversionDone;
            cdSync2_r <= cdSync1_r;
            cdSync3_r <= cdSync2_r;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cdLevel_r <= CONV_DONE_IDLE;
        end else if (cdAgree) begin
            cdLevel_r <= cdSync3_r;
        end
    end

    always_comb begin
        seq_nxt = seq_r;
        case (seq_r)
            SEQ_DISARMED: begin
                if (armCapture) begin
                    seq_nxt = SEQ_CAPTURE;
                end
            end
            SEQ_CAPTURE: begin
                if (armCapture) begin
                    seq_nxt = SEQ_CAPTURE;
                end else if (blockLast) begin
                    seq_nxt = SEQ_DISCARD;
                end
            end
            SEQ_DISCARD: begin
                if (armCapture) begin
                    seq_nxt = SEQ_CAPTURE;
                end
            end
            default: begin
                seq_nxt = SEQ_DISARMED;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            seq_r             <= SEQ_DISARMED;
            captureActive_r   <= 1'h0;
            captureComplete_r <= 1'h0;
        end else begin
            seq_r             <= seq_nxt;
            captureActive_r   <= (seq_nxt == SEQ_CAPTURE);
            captureComplete_r <= (seq_nxt == SEQ_DISCARD);
        end
    end

    always_comb begin
        ser_nxt = ser_r;
        case (ser_r)
            SER_IDLE: begin
                if (frameStart) begin
                    ser_nxt = SER_LEAD;
                end
            end
            SER_LEAD: begin
                if (leadDone) begin
                    ser_nxt = SER_SHIFT;
                end
            end
            SER_SHIFT: begin
                if (frameEnd) begin
                    ser_nxt = SER_IDLE;
                end
            end
            default: begin
                ser_nxt = SER_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ser_r <= SER_IDLE;
        end else begin
            ser_r <= ser_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || ser_r == SER_IDLE || halfTick) begin
            halfCnt_r <= 4'h0;
        end else begin
            halfCnt_r <= halfCnt_r + 4'h1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || frameStart || leadDone) begin
            bitCnt_r <= 5'h00;
        end else if ((ser_r == SER_LEAD && halfTick) || fallTick) begin
            bitCnt_r <= bitCnt_r + 5'h01;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sclk_r <= SCLK_IDLE;
        end else if (riseTick) begin
            sclk_r <= 1'h1;
        end else if (fallTick) begin
            sclk_r <= SCLK_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            frameSel_r <= FRAME_SEL_IDLE;
        end else if (frameStart) begin
            frameSel_r <= 1'h0;
        end else if (frameEnd) begin
            frameSel_r <= FRAME_SEL_IDLE;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            transmitWord_r <= 16'h0000;
        end else if (cmdLoad) begin
            transmitWord_r <= CMD_READ_DATA;
        end
    end

    // A new edge in the same cycle as a frame start keeps the request pending.
    assign txPending_nxt = cmdLoad || (txPending_r && !frameStart && !armCapture);

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txPending_r <= 1'h0;
        end else begin
            txPending_r <= txPending_nxt;
        end
    end

    // An edge that finds an unsent command means a conversion result was skipped.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            overrun_r <= 1'h0;
        end else if (cmdLoad && txPending_r && !frameStart) begin
            overrun_r <= 1'h1;
        end else if (armCapture) begin
            overrun_r <= 1'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            txShift_r   <= 16'h0000;
            serialOut_r <= 1'h0;
        end else if (frameStart) begin
            txShift_r   <= transmitWord_r;
            serialOut_r <= transmitWord_r[FRAME_BITS-1];
        end else if (fallTick) begin
            txShift_r   <= {txShift_r[FRAME_BITS-2:0], 1'h0};
            serialOut_r <= lastBit ? 1'h0 : txShift_r[FRAME_BITS-2];
        end
    end

    // The converter changes its data on the falling edge, so it is taken on the rising one.
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            rxShift_r <= 16'h0000;
        end else if (riseTick) begin
            rxShift_r <= {rxShift_r[FRAME_BITS-2:0], converterSerialOut};
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            receiveWord_r  <= 16'h0000;
            receiveReady_r <= 1'h0;
        end else begin
            receiveWord_r  <= frameEnd ? rxShift_r : receiveWord_r;
            receiveReady_r <= frameEnd;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset || armCapture) begin
            storeCount_r <= 17'h00000;
        end else if (storeTake && isCapturing(storeCount_r)) begin
            storeCount_r <= storeCount_r + 17'h00001;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (storeTake) begin
            memWrAddr_r <= storeAddr(storeCount_r);
            memWrData_r <= fifoOut.data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            memWrEn_r <= 1'h0;
        end else if (storeTake) begin
            memWrEn_r <= 1'h1;
        end else if (memWrReady) begin
            memWrEn_r <= 1'h0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            blockDone_r <= 1'h0;
        end else begin
            blockDone_r <= blockLast;
        end
    end

endmodule

// ---- verilog/acs_fifo.sv ----
/*
 * Receive buffer: a first-in first-out store with a registered output stage.
 * Assumes one clock, a synchronous reset and a one-cycle flush from the owner.
 */
`timescale 1ns/10ps
module acs_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic reset,
    input  wire logic flush,
    // Stream in and out.
    acs_stream_if.snk inPort,
    acs_stream_if.src outPort
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [AW:0]      count_r;
    logic [AW:0]      count_nxt;
    logic             outValid_r;
    logic [WIDTH-1:0] outData_r;

    wire push = inPort.valid && inPort.ready;
    wire pop  = (count_r != '0) && (!outValid_r || outPort.ready);

    assign inPort.ready  = (count_r != (AW+1)'(DEPTH));
    assign outPort.valid = outValid_r;
    assign outPort.data  = outData_r;

    always_comb begin
        count_nxt = count_r;
        if (push && !pop) begin
            count_nxt = count_r + 1'h1;
        end else if (pop && !push) begin
            count_nxt = count_r - 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr_r] <= inPort.data;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || flush) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            wrPtr_r <= push ? wrPtr_r + 1'h1 : wrPtr_r;
            rdPtr_r <= pop ? rdPtr_r + 1'h1 : rdPtr_r;
            count_r <= count_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (reset || flush) begin
            outValid_r <= 1'h0;
        end else if (pop) begin
            outValid_r <= 1'h1;
        end else if (outPort.ready) begin
            outValid_r <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (pop) begin
            outData_r <= mem[rdPtr_r];
        end
    end

endmodule

// ---- verilog/acs_pkg.sv ----
/*
 * Shared constants and types of the converter capture sequencer.
 * Assumes a single 50 MHz system clock and a synchronous, active-high reset.
 */
package acs_pkg;

    // System clock and the reference shift rate of the serial port.
    localparam int CLK_HZ            = 50_000_000;
    localparam int SCLK_REF_HZ       = 37_500_000;
    // Rounded up, so the shift clock never runs faster than the reference rate.
    localparam int SCLK_HALF_RAW     = (CLK_HZ + 2 * SCLK_REF_HZ - 1) / (2 * SCLK_REF_HZ);
    localparam int SCLK_HALF_CYC     = (SCLK_HALF_RAW < 1) ? 1 : SCLK_HALF_RAW;

    // Serial frame layout.
    localparam int FRAME_BITS        = 16;
    localparam int LEAD_HALVES       = 2;

    // Capture block size and buffer addressing.
    localparam int WORDS_PER_CHANNEL = 32768;
    localparam int CHANNEL_COUNT     = 2;
    localparam int BLOCK_WORDS       = WORDS_PER_CHANNEL * CHANNEL_COUNT;
    localparam int STORE_ADDR_W      = 17;
    localparam logic [16:0] BLOCK_WORDS_W = 17'h10000;
    localparam logic [16:0] DISCARD_ADDR  = 17'h10000;

    // Command word that asks the converter for its last result.
    localparam logic [15:0] CMD_READ_DATA = 16'hD000;

    // Receive buffer between the serial port and the capture buffer writer.
    localparam int FIFO_WIDTH        = 16;
    localparam int FIFO_DEPTH        = 32;

    // Reset and idle levels of the pins.
    localparam logic CONV_DONE_IDLE  = 1'h1;
    localparam logic FRAME_SEL_IDLE  = 1'h1;
    localparam logic SCLK_IDLE       = 1'h0;

    typedef enum logic [1:0] {
        SEQ_DISARMED,
        SEQ_CAPTURE,
        SEQ_DISCARD
    } acs_seq_state_t;

    typedef enum logic [1:0] {
        SER_IDLE,
        SER_LEAD,
        SER_SHIFT
    } acs_ser_state_t;

endpackage

// ---- verilog/acs_stream_if.sv ----
/*
 * Valid/ready word stream used between the sequencer and its receive buffer.
 * Assumes both ends sit on the same clock.
 */
`timescale 1ns/10ps
interface acs_stream_if #(
    parameter int WIDTH = 16
);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface
